// ### design/pcs_feature_mask.sv
`timescale 1ns/1ps
`include "pcs_defs.svh"

module pcs_feature_mask (
  input wire logic core_clk,
  input wire logic srst,
  pcs_mask_if.store mif
);
  import pcs_pkg::*;

  pcs_mask_type mask_q;

  assign mif.mask = mask_q;

  // Own storage per feature; only a selected feature sees wr_en
  always_ff @(posedge core_clk) begin
    if (srst || mif.clr) begin
      mask_q <= `PCS_RST_MASK;
    end else if (mif.wr_en) begin
      mask_q[8*mif.byte_idx +: 8] <= mif.wdata;
    end
  end

  chk_byte_store: assert property (@(posedge core_clk) disable iff (srst)
    mif.wr_en && !mif.clr |=> mask_q[8*$past(mif.byte_idx) +: 8] == $past(mif.wdata))
    else $error("mask byte not stored");

  chk_mask_hold: assert property (@(posedge core_clk) disable iff (srst)
    !mif.wr_en && !mif.clr |=> $stable(mask_q))
    else $error("mask changed without a write");

endmodule : pcs_feature_mask

// ### design/pcs_regs.sv
// Summary of operation
// - Pointer bits choose features for mask writes
// - Bits 0-3: tx pattern, fractional, error, signalling
// - Bits 4-7: rx pattern, fractional, reinsert, ones
// - Mask write stores byte into every selected feature
// - Channel n is bit (n-1)%8, ascending bytes
// - Pointer at 28h, mask bytes 29h to 2Ch
// - Reset clears pointer, masks and configuration
// - Software reset bit clears space, self-clears
// - Master bit 1: 0 is T1, 1 is E1
`timescale 1ns/1ps
`include "pcs_defs.svh"

module pcs_regs (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire pcs_pkg::pcs_addr_type reg_addr,
  input wire pcs_pkg::pcs_byte_type reg_wdata,
  output pcs_pkg::pcs_byte_type reg_rdata,
  output logic reg_rvalid,
  output logic e1_mode,
  output logic [1:0] test_mode,
  output logic soft_reset_busy,
  output pcs_pkg::pcs_mask_type tx_pattern_tester_mask,
  output pcs_pkg::pcs_mask_type tx_fractional_mask,
  output pcs_pkg::pcs_mask_type payload_error_insert_mask,
  output pcs_pkg::pcs_mask_type tx_hw_signalling_mask,
  output pcs_pkg::pcs_mask_type rx_pattern_tester_mask,
  output pcs_pkg::pcs_mask_type rx_fractional_mask,
  output pcs_pkg::pcs_mask_type rx_signalling_reinsert_mask,
  output pcs_pkg::pcs_mask_type rx_signalling_all_ones_mask
);
  import pcs_pkg::*;

  pcs_byte_type channel_function_pointer_q;
  pcs_byte_type master_mode_register_q;
  pcs_byte_type rdata_q;
  pcs_byte_type rdata_d;
  logic rvalid_q;
  pcs_rst_state_type rst_state_q;
  logic wr_acc;
  logic rd_acc;
  logic mask_addr_hit;
  logic soft_trigger;
  logic clr_all;
  pcs_byte_idx_type mask_byte_idx;
  logic [`PCS_MASK_W-1:0] feat_mask [`PCS_NUM_FEAT];

  pcs_mask_if mif [`PCS_NUM_FEAT] ();

  // Writes during the clearing cycle are dropped so nothing survives the reset
  assign wr_acc = reg_cs && reg_wr && (rst_state_q == PCS_RST_IDLE);
  assign rd_acc = reg_cs && reg_rd;
  assign mask_addr_hit = (reg_addr >= `PCS_ADDR_MASK1) && (reg_addr <= `PCS_ADDR_MASK4);
  assign mask_byte_idx = 2'(reg_addr - `PCS_ADDR_MASK1);
  assign soft_trigger = wr_acc && (reg_addr == `PCS_ADDR_MSTR)
    && reg_wdata[`PCS_MSTR_SOFT_RESET_BIT]
    && !master_mode_register_q[`PCS_MSTR_SOFT_RESET_BIT];
  assign clr_all = (rst_state_q == PCS_RST_CLEAR);

  genvar gi;
  generate
    for (gi = 0; gi < `PCS_NUM_FEAT; gi++) begin : g_feat
      assign mif[gi].wr_en = wr_acc && mask_addr_hit
        && channel_function_pointer_q[gi];
      assign mif[gi].clr = clr_all;
      assign mif[gi].byte_idx = mask_byte_idx;
      assign mif[gi].wdata = reg_wdata;
      assign feat_mask[gi] = mif[gi].mask;
      pcs_feature_mask u_mask (
        .core_clk(core_clk),
        .srst(srst),
        .mif(mif[gi])
      );
    end
  endgenerate

  // Pointer bit order fixes which store drives which feature
  assign tx_pattern_tester_mask = feat_mask[`PCS_FEAT_TX_PATTERN];
  assign tx_fractional_mask = feat_mask[`PCS_FEAT_TX_FRACT];
  assign payload_error_insert_mask = feat_mask[`PCS_FEAT_PAYLOAD_ERR];
  assign tx_hw_signalling_mask = feat_mask[`PCS_FEAT_TX_HW_SIG];
  assign rx_pattern_tester_mask = feat_mask[`PCS_FEAT_RX_PATTERN];
  assign rx_fractional_mask = feat_mask[`PCS_FEAT_RX_FRACT];
  assign rx_signalling_reinsert_mask = feat_mask[`PCS_FEAT_RX_SIG_REINS];
  assign rx_signalling_all_ones_mask = feat_mask[`PCS_FEAT_RX_SIG_ONES];

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign e1_mode = master_mode_register_q[`PCS_MSTR_E1_BIT];
  assign test_mode = master_mode_register_q[`PCS_MSTR_TEST_LSB +: 2];
  assign soft_reset_busy = master_mode_register_q[`PCS_MSTR_SOFT_RESET_BIT];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_state_q <= PCS_RST_IDLE;
    end else begin
      case (rst_state_q)
        PCS_RST_IDLE: begin
          if (soft_trigger) begin
            rst_state_q <= PCS_RST_CLEAR;
          end
        end
        PCS_RST_CLEAR: begin
          rst_state_q <= PCS_RST_IDLE;
        end
        default: begin
          rst_state_q <= PCS_RST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || clr_all) begin
      channel_function_pointer_q <= `PCS_RST_PTR;
    end else if (wr_acc && reg_addr == `PCS_ADDR_PTR) begin
      channel_function_pointer_q <= reg_wdata;
    end
  end

  // Clear step also drops the reset bit, so it reads back 0 once done
  always_ff @(posedge core_clk) begin
    if (srst || clr_all) begin
      master_mode_register_q <= `PCS_RST_MSTR;
    end else if (wr_acc && reg_addr == `PCS_ADDR_MSTR) begin
      master_mode_register_q <= reg_wdata & `PCS_MSTR_USED_MASK;
    end
  end

  // Several selected features read as their OR; only one gives a clean value
  always_comb begin
    rdata_d = `PCS_RST_RDATA;
    if (reg_addr == `PCS_ADDR_MSTR) begin
      rdata_d = master_mode_register_q;
    end else if (reg_addr == `PCS_ADDR_PTR) begin
      rdata_d = channel_function_pointer_q;
    end else if (mask_addr_hit) begin
      for (int i = 0; i < `PCS_NUM_FEAT; i++) begin
        if (channel_function_pointer_q[i]) begin
          rdata_d = rdata_d | feat_mask[i][8*mask_byte_idx +: 8];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= `PCS_RST_RDATA;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_acc;
      if (rd_acc) begin
        rdata_q <= rdata_d;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // Checked as reset falls; a plain srst antecedent would be disabled by itself
  chk_ptr_hw_reset: assert property ($fell(srst) |->
    channel_function_pointer_q == 8'h00
    && tx_fractional_mask == 32'h0000_0000 && !e1_mode)
    else $error("hardware reset left state");

  chk_soft_clear: assert property (soft_trigger |=> soft_reset_busy ##1
    (!soft_reset_busy && channel_function_pointer_q == 8'h00
    && rx_signalling_all_ones_mask == 32'h0000_0000))
    else $error("software reset did not clear and self-clear");

  chk_mode_select: assert property (wr_acc && reg_addr == 8'h00 && !soft_trigger
    |=> e1_mode == $past(reg_wdata[1]) && test_mode == $past(reg_wdata[3:2]))
    else $error("mode bits not written");

  chk_ptr_write: assert property (wr_acc && reg_addr == 8'h28
    |=> channel_function_pointer_q == $past(reg_wdata))
    else $error("pointer write lost");

  chk_ch24_map: assert property (wr_acc && reg_addr == 8'h2b
    && channel_function_pointer_q[0] |=> tx_pattern_tester_mask[23] == $past(reg_wdata[7]))
    else $error("channel 24 not at mask bit 23");

  chk_multi_write: assert property (wr_acc && reg_addr == 8'h29
    && channel_function_pointer_q[1] && channel_function_pointer_q[4]
    |=> tx_fractional_mask[7:0] == rx_pattern_tester_mask[7:0])
    else $error("multi-feature write diverged");

  chk_unselected_hold: assert property (!channel_function_pointer_q[5]
    && !clr_all |=> $stable(rx_fractional_mask))
    else $error("unselected feature mask changed");

  chk_single_read: assert property (rd_acc && reg_addr == 8'h2a
    && channel_function_pointer_q == 8'h10
    |=> reg_rvalid && reg_rdata == $past(rx_pattern_tester_mask[15:8]))
    else $error("single-feature read wrong");

  cov_multi_write: cover property (wr_acc && mask_addr_hit
    && $countones(channel_function_pointer_q) > 1);
  cov_soft_reset: cover property (soft_trigger ##2 !soft_reset_busy);
  cov_read_back: cover property (rd_acc && mask_addr_hit ##1 reg_rvalid);

endmodule : pcs_regs

// ### include/pcs_defs.svh
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

`define PCS_ADDR_W 8
`define PCS_DATA_W 8
`define PCS_NUM_FEAT 8
`define PCS_NUM_BYTES 4
`define PCS_MASK_W 32

`define PCS_ADDR_MSTR 8'h00
`define PCS_ADDR_PTR 8'h28
`define PCS_ADDR_MASK1 8'h29
`define PCS_ADDR_MASK2 8'h2a
`define PCS_ADDR_MASK3 8'h2b
`define PCS_ADDR_MASK4 8'h2c

`define PCS_MSTR_SOFT_RESET_BIT 0
`define PCS_MSTR_E1_BIT 1
`define PCS_MSTR_TEST_LSB 2
`define PCS_MSTR_USED_MASK 8'h0f

`define PCS_FEAT_TX_PATTERN 0
`define PCS_FEAT_TX_FRACT 1
`define PCS_FEAT_PAYLOAD_ERR 2
`define PCS_FEAT_TX_HW_SIG 3
`define PCS_FEAT_RX_PATTERN 4
`define PCS_FEAT_RX_FRACT 5
`define PCS_FEAT_RX_SIG_REINS 6
`define PCS_FEAT_RX_SIG_ONES 7

`define PCS_RST_PTR 8'h00
`define PCS_RST_MSTR 8'h00
`define PCS_RST_MASK 32'h0000_0000
`define PCS_RST_RDATA 8'h00

`endif

// ### include/pcs_mask_if.sv
`timescale 1ns/1ps
`include "pcs_defs.svh"

interface pcs_mask_if;
  import pcs_pkg::*;
  logic wr_en;
  logic clr;
  pcs_byte_idx_type byte_idx;
  pcs_byte_type wdata;
  pcs_mask_type mask;
  modport ctrl (output wr_en, output clr, output byte_idx, output wdata, input mask);
  modport store (input wr_en, input clr, input byte_idx, input wdata, output mask);
endinterface : pcs_mask_if

// ### include/pcs_pkg.sv
`include "pcs_defs.svh"

package pcs_pkg;
  typedef logic [`PCS_ADDR_W-1:0] pcs_addr_type;
  typedef logic [`PCS_DATA_W-1:0] pcs_byte_type;
  typedef logic [`PCS_MASK_W-1:0] pcs_mask_type;
  typedef logic [1:0] pcs_byte_idx_type;
  typedef enum logic [0:0] {
    PCS_RST_IDLE = 1'b0,
    PCS_RST_CLEAR = 1'b1
  } pcs_rst_state_type;
endpackage : pcs_pkg

// ### verification/pcs_regs_tb_top.sv
`timescale 1ns/1ps
`include "pcs_defs.svh"

module pcs_regs_tb_top;
  import pcs_pkg::*;
  logic core_clk;
  logic srst;
  logic reg_cs;
  logic reg_wr;
  logic reg_rd;
  pcs_addr_type reg_addr;
  pcs_byte_type reg_wdata;
  pcs_byte_type reg_rdata;
  logic reg_rvalid;
  logic e1_mode;
  logic [1:0] test_mode;
  logic soft_reset_busy;
  pcs_mask_type m [8];
  pcs_mask_type exp_m [8];
  int num_errors = 0;
  int tests_run = 0;

  pcs_regs DUT (.core_clk(core_clk), .srst(srst), .reg_cs(reg_cs), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .e1_mode(e1_mode), .test_mode(test_mode),
    .soft_reset_busy(soft_reset_busy), .tx_pattern_tester_mask(m[0]),
    .tx_fractional_mask(m[1]), .payload_error_insert_mask(m[2]),
    .tx_hw_signalling_mask(m[3]), .rx_pattern_tester_mask(m[4]), .rx_fractional_mask(m[5]),
    .rx_signalling_reinsert_mask(m[6]), .rx_signalling_all_ones_mask(m[7]));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task end_sim;
    $display("checks=%0d errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : chk

  // Strobes stay up between calls so back-to-back accesses never double-assign
  task wr(input pcs_addr_type a, input pcs_byte_type d);
    reg_cs = 1'b1;
    reg_wr = 1'b1;
    reg_rd = 1'b0;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
  endtask : wr

  task rd(input pcs_addr_type a, input pcs_byte_type want);
    reg_cs = 1'b1;
    reg_rd = 1'b1;
    reg_wr = 1'b0;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    chk(reg_rvalid, 1'b1);
    chk(reg_rdata, want);
  endtask : rd

  task idle;
    reg_cs = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(posedge core_clk);
    #1;
  endtask : idle

  task chk_masks;
    for (int i = 0; i < 8; i++) chk(m[i], exp_m[i]);
  endtask : chk_masks

  task put(input pcs_byte_type ptr, input int b, input pcs_byte_type d);
    wr(8'h29 + pcs_addr_type'(b), d);
    for (int i = 0; i < 8; i++) if (ptr[i]) exp_m[i][b*8 +: 8] = d;
    chk_masks();
  endtask : put

  task clear_exp;
    foreach (exp_m[i]) exp_m[i] = `PCS_RST_MASK;
  endtask : clear_exp

  // Whole run is about 70 cycles (under 2 us); this limit only trips on a hang
  initial begin
    #50us;
    num_errors++;
    end_sim();
  end

  initial begin
    srst = 1'b1;
    reg_cs = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    clear_exp();
    repeat (12) @(posedge core_clk);
    #1 srst = 1'b0;
    chk_masks();
    for (int a = 0; a < 5; a++) rd(8'h28 + pcs_addr_type'(a), 8'h00);
    rd(`PCS_ADDR_MSTR, 8'h00);
    idle();
    $display("test reset_values done");
    wr(`PCS_ADDR_PTR, 8'h11);
    put(8'h11, 0, 8'h00);
    put(8'h11, 1, 8'h0f);
    put(8'h11, 2, 8'h18);
    put(8'h11, 3, 8'h00);
    chk(m[4], 32'h0018_0f00);
    rd(`PCS_ADDR_PTR, 8'h11);
    $display("test two_features done");
    for (int i = 0; i < 8; i++) begin
      wr(`PCS_ADDR_PTR, 8'h01 << i);
      put(8'h01 << i, i % 4, 8'ha0 + pcs_byte_type'(i));
      rd(8'h29 + pcs_addr_type'(i % 4), exp_m[i][(i%4)*8 +: 8]);
    end
    // Channel 24 set to 1 so a misplaced bit cannot pass as a zero
    wr(`PCS_ADDR_PTR, 8'h01);
    put(8'h01, 2, 8'h81);
    chk(m[0][23], 1'b1);
    wr(`PCS_ADDR_PTR, 8'h10);
    rd(8'h2a, exp_m[4][15:8]);
    $display("test single_features done");
    rd(8'h2d, 8'h00);
    wr(8'h2d, 8'hff);
    chk_masks();
    wr(`PCS_ADDR_MSTR, 8'h0e);
    chk(e1_mode, 1'b1);
    chk(test_mode, 2'h3);
    rd(`PCS_ADDR_MSTR, 8'h0e);
    wr(`PCS_ADDR_MSTR, 8'h0c);
    chk(e1_mode, 1'b0);
    wr(`PCS_ADDR_MSTR, 8'h0d);
    chk(soft_reset_busy, 1'b1);
    wr(`PCS_ADDR_PTR, 8'hff);
    chk(soft_reset_busy, 1'b0);
    clear_exp();
    chk_masks();
    rd(`PCS_ADDR_PTR, 8'h00);
    rd(`PCS_ADDR_MSTR, 8'h00);
    $display("test soft_reset done");
    wr(`PCS_ADDR_MSTR, 8'h02);
    wr(`PCS_ADDR_PTR, 8'hff);
    put(8'hff, 3, 8'h5a);
    put(8'hff, 0, 8'h3c);
    idle();
    srst = 1'b1;
    @(posedge core_clk);
    #1;
    srst = 1'b0;
    clear_exp();
    chk_masks();
    chk(e1_mode, 1'b0);
    rd(`PCS_ADDR_PTR, 8'h00);
    idle();
    $display("test mid_run_reset done");
    end_sim();
  end
endmodule : pcs_regs_tb_top
